//--- logic/usbsie_top.sv
// usb sie status window fifo, endpoint control, address, frame number, usb ram, eye test
// assumes: sie engine on the same clock drives token, done, sof and ram ports; axi4-lite master
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "usbsie_consts.svh"

module usbsie_top #(
  parameter int NUM_EP = 8,
  parameter int FS_BIT_CYC = `USBSIE_FS_BIT_CYC,
  parameter int LS_BIT_CYC = `USBSIE_LS_BIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire usbsie_pkg::usbsie_token_type token,
  output logic hs_valid,
  output usbsie_pkg::usbsie_hs_type hs_code,
  input wire usbsie_pkg::usbsie_done_type xfer_done,
  input wire usbsie_pkg::usbsie_sof_type sof,
  input wire logic bus_reset_flag,
  input wire logic suspend_request,
  input wire usbsie_pkg::usbsie_ram_req_type sie_ram,
  output logic [7:0] sie_ram_rdata,
  output logic transaction_done_flag,
  output logic eye_tx_en,
  output logic eye_dp,
  output logic eye_dm
);
  import usbsie_pkg::*;

  // ==========================================================
  // address decoding
  function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic reg_hit(input logic [15:0] a);
    reg_hit = (a == `USBSIE_OFF_CFG) || (a == `USBSIE_OFF_DONE) || (a == `USBSIE_OFF_WINDOW) ||
              (a == `USBSIE_OFF_ADDR) || (a == `USBSIE_OFF_FRML) || (a == `USBSIE_OFF_FRMH) ||
              ((a[15:2] >= `USBSIE_OFF_EP_BASE >> 2) &&
               (a[15:2] < (`USBSIE_OFF_EP_BASE >> 2) + 14'(NUM_EP)));
  endfunction

  // ==========================================================
  // state
  logic [2:0] cfg_q;
  logic [6:0] dev_addr_q;
  logic [10:0] frame_q;
  logic [4:0] ep_ctrl_q [NUM_EP];
  usbsie_status_type fifo_q [`USBSIE_FIFO_DEPTH];
  logic [1:0] rd_ptr_q;
  logic [1:0] wr_ptr_q;
  logic [2:0] count_q;
  logic done_q;
  logic [7:0] dp_mem [`USBSIE_DP_BYTES];
  logic [7:0] sp_mem [`USBSIE_SP_BYTES];

  // ==========================================================
  // axi4-lite write channel
  logic aw_have_q;
  logic [15:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire bvalid_d = (bvalid_q && !s_axi_bready) || (aw_have_q && w_have_q && !bvalid_q);
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire aw_have_d = (aw_have_q && !wr_go) || aw_take;
  wire w_have_d = (w_have_q && !wr_go) || w_take;
  wire [13:0] wr_lin = aw_addr_q[15:2];
  wire wr_dp = in_range(wr_lin, `USBSIE_DP_FIRST, `USBSIE_DP_LAST);
  wire wr_sp = in_range(wr_lin, `USBSIE_SP_FIRST, `USBSIE_SP_LAST);
  wire wr_zero = in_range(wr_lin, `USBSIE_DP_LAST + 14'h1, `USBSIE_ZERO_LAST);
  wire wr_ok = reg_hit(aw_addr_q) || wr_dp || wr_sp || wr_zero;
  wire wr_en = wr_go && w_strb0_q;
  wire [7:0] wbyte = w_data_q[7:0];
  wire wr_cfg = wr_en && (aw_addr_q == `USBSIE_OFF_CFG);
  wire wr_done = wr_en && (aw_addr_q == `USBSIE_OFF_DONE);
  wire wr_addr = wr_en && (aw_addr_q == `USBSIE_OFF_ADDR);
  wire [15:0] wr_ep_off = aw_addr_q - `USBSIE_OFF_EP_BASE;
  wire [`USBSIE_EP_IDX_W-1:0] wr_ep_idx = wr_ep_off[`USBSIE_EP_IDX_LSB +: `USBSIE_EP_IDX_W];
  wire [8:0] dp_wr_idx = 9'(wr_lin - `USBSIE_DP_FIRST);
  wire [8:0] sp_wr_idx = 9'(wr_lin - `USBSIE_SP_FIRST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      aw_addr_q <= 16'h0000;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= !aw_have_d && !aw_take;
      wready_q <= !w_have_d && !w_take;
      bvalid_q <= bvalid_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel, one cycle lookup
  logic rd_pend_q;
  logic [15:0] ar_addr_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid && arready_q;
  wire rvalid_d = (rvalid_q && !s_axi_rready) || rd_pend_q;
  wire [13:0] rd_lin = ar_addr_q[15:2];
  wire rd_dp = in_range(rd_lin, `USBSIE_DP_FIRST, `USBSIE_DP_LAST);
  wire rd_sp = in_range(rd_lin, `USBSIE_SP_FIRST, `USBSIE_SP_LAST);
  wire rd_zero = in_range(rd_lin, `USBSIE_DP_LAST + 14'h1, `USBSIE_ZERO_LAST);
  wire rd_ok = reg_hit(ar_addr_q) || rd_dp || rd_sp || rd_zero;
  wire [15:0] rd_ep_off = ar_addr_q - `USBSIE_OFF_EP_BASE;
  wire [`USBSIE_EP_IDX_W-1:0] rd_ep_idx = rd_ep_off[`USBSIE_EP_IDX_LSB +: `USBSIE_EP_IDX_W];
  wire rd_ep = reg_hit(ar_addr_q) && (ar_addr_q >= `USBSIE_OFF_EP_BASE);
  usbsie_status_type head;
  assign head = fifo_q[rd_ptr_q];
  wire [7:0] window_byte = {1'b0, head.ep, head.dir, head.ppbi, 1'b0};
  wire [7:0] rd_byte =
    rd_dp ? dp_mem[9'(rd_lin - `USBSIE_DP_FIRST)] :
    rd_sp ? sp_mem[9'(rd_lin - `USBSIE_SP_FIRST)] :
    rd_ep ? {3'h0, ep_ctrl_q[rd_ep_idx]} :
    (ar_addr_q == `USBSIE_OFF_CFG) ? {5'h00, cfg_q} :
    (ar_addr_q == `USBSIE_OFF_DONE) ? {7'h00, done_q} :
    (ar_addr_q == `USBSIE_OFF_WINDOW) ? window_byte :
    (ar_addr_q == `USBSIE_OFF_ADDR) ? {1'b0, dev_addr_q} :
    (ar_addr_q == `USBSIE_OFF_FRML) ? frame_q[7:0] :
    (ar_addr_q == `USBSIE_OFF_FRMH) ? {5'h00, frame_q[10:8]} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      ar_addr_q <= 16'h0000;
    end else begin
      rd_pend_q <= ar_take;
      arready_q <= !rvalid_d && !ar_take && !rd_pend_q;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        ar_addr_q <= s_axi_araddr;
      end
      if (rd_pend_q) begin
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= rd_ok ? 2'h0 : 2'h2;
      end
    end
  end

  // ==========================================================
  // configuration and device address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= 3'h0;
      dev_addr_q <= `USBSIE_ADDR_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wbyte[2:0];
      end
      if (bus_reset_flag) begin
        dev_addr_q <= `USBSIE_ADDR_RESET;
      end else if (wr_addr) begin
        dev_addr_q <= wbyte[6:0];
      end
    end
  end

  // ==========================================================
  // frame number, held between sof tokens
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q <= 11'h000;
    end else if (sof.valid) begin
      frame_q <= sof.frame;
    end
  end

  // ==========================================================
  // token decision
  wire tok_ep_ok = token.ep < 4'(NUM_EP);
  wire [`USBSIE_EP_IDX_W-1:0] tok_idx = token.ep[`USBSIE_EP_IDX_W-1:0];
  wire [4:0] tok_ctrl = tok_ep_ok ? ep_ctrl_q[tok_idx] : 5'h00;
  wire fifo_full = count_q == 3'(`USBSIE_FIFO_DEPTH);
  wire tok_dir_ok =
    (token.kind == USBSIE_TOK_SETUP) ? !tok_ctrl[`USBSIE_EP_SETUP_DIS] :
    (token.kind == USBSIE_TOK_IN) ? tok_ctrl[`USBSIE_EP_IN_EN] :
    tok_ctrl[`USBSIE_EP_OUT_EN];
  wire tok_ours = (token.addr == dev_addr_q) && tok_ep_ok && tok_dir_ok;
  wire tok_stall = token.valid && tok_ours && !fifo_full && token.bd_stall;
  usbsie_hs_type hs_d;
  assign hs_d = !tok_ours ? USBSIE_HS_IGNORE :
                fifo_full ? USBSIE_HS_NAK :
                token.bd_stall ? USBSIE_HS_STALL :
                !tok_ctrl[`USBSIE_EP_HSHK] ? USBSIE_HS_NONE :
                token.buf_ready ? USBSIE_HS_ACK : USBSIE_HS_NAK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_valid <= 1'b0;
      hs_code <= USBSIE_HS_IGNORE;
    end else begin
      hs_valid <= token.valid;
      if (token.valid) begin
        hs_code <= hs_d;
      end
    end
  end

  // ==========================================================
  // endpoint control registers, one per endpoint pair
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      wire sw_wr = wr_en && reg_hit(aw_addr_q) && (aw_addr_q >= `USBSIE_OFF_EP_BASE) &&
                   (wr_ep_idx == `USBSIE_EP_IDX_W'(gi));
      wire hw_stall = tok_stall && (tok_idx == `USBSIE_EP_IDX_W'(gi));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ep_ctrl_q[gi] <= 5'h00;
        end else begin
          if (sw_wr) begin
            ep_ctrl_q[gi] <= wbyte[4:0];
          end
          if (hw_stall) begin
            ep_ctrl_q[gi][`USBSIE_EP_STALL] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // status fifo behind the window and the done flag
  wire pop = wr_done && wbyte[0] && done_q && (count_q != 3'h0);
  wire push = xfer_done.valid && (!fifo_full || pop);
  wire [2:0] count_d = 3'(count_q + {2'h0, push} - {2'h0, pop});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_q <= 2'h0;
      wr_ptr_q <= 2'h0;
      count_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= xfer_done.status;
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      count_q <= count_d;
      // flag rises the cycle after the head is written
      done_q <= !pop && (count_q != 3'h0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transaction_done_flag <= 1'b0;
    end else begin
      transaction_done_flag <= !pop && (count_q != 3'h0);
    end
  end

  // ==========================================================
  // usb ram, sie wins a write collision on the dual-port part
  always_ff @(posedge aclk) begin
    if (wr_en && wr_dp && !(sie_ram.we && sie_ram.addr == dp_wr_idx)) begin
      dp_mem[dp_wr_idx] <= wbyte;
    end
    if (sie_ram.we && sie_ram.addr < 9'(`USBSIE_DP_BYTES)) begin
      dp_mem[sie_ram.addr] <= sie_ram.wdata;
    end
    if (wr_en && wr_sp) begin
      sp_mem[sp_wr_idx] <= wbyte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sie_ram_rdata <= 8'h00;
    end else if (sie_ram.addr < 9'(`USBSIE_DP_BYTES)) begin
      sie_ram_rdata <= dp_mem[sie_ram.addr];
    end else begin
      sie_ram_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // eye pattern generator
  usbsie_eye_type eye_q;
  logic [15:0] div_q;
  logic kstate_q;
  wire full_speed = cfg_q[`USBSIE_CFG_FULL_SPEED];
  wire eye_on = cfg_q[`USBSIE_CFG_EYE] && cfg_q[`USBSIE_CFG_MOD_EN];
  wire [15:0] div_last = full_speed ? 16'(FS_BIT_CYC - 1) : 16'(LS_BIT_CYC - 1);
  wire bit_tick = div_q >= div_last;
  // j is dp high at full speed and dm high at low speed
  wire line_dp = full_speed ? !kstate_q : kstate_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eye_q <= USBSIE_EYE_IDLE;
      div_q <= 16'h0000;
      kstate_q <= 1'b0;
      eye_tx_en <= 1'b0;
      eye_dp <= 1'b0;
      eye_dm <= 1'b0;
    end else begin
      div_q <= (bit_tick || !eye_on) ? 16'h0000 : div_q + 16'h0001;
      case (eye_q)
        USBSIE_EYE_IDLE: begin
          eye_tx_en <= 1'b0;
          if (eye_on) begin
            eye_q <= USBSIE_EYE_SWITCH;
          end
        end
        USBSIE_EYE_SWITCH: begin
          // one bit time of receive-to-transmit turnaround
          kstate_q <= full_speed;
          if (!eye_on) begin
            eye_q <= USBSIE_EYE_IDLE;
          end else if (bit_tick) begin
            eye_q <= USBSIE_EYE_RUN;
          end
        end
        USBSIE_EYE_RUN: begin
          eye_tx_en <= eye_on;
          eye_dp <= line_dp;
          eye_dm <= !line_dp;
          if (!eye_on) begin
            eye_q <= USBSIE_EYE_IDLE;
          end else if (bit_tick) begin
            kstate_q <= !kstate_q;
          end
        end
        default: begin
          eye_q <= USBSIE_EYE_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // axi outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

//--- logic/usbsie_consts.svh
// constants of the usb sie status and endpoint control block
// assumes: included by bare name from the top module
`ifndef USBSIE_CONSTS_SVH
`define USBSIE_CONSTS_SVH

// ==========================================================
// register byte offsets
`define USBSIE_OFF_CFG 16'h0000
`define USBSIE_OFF_DONE 16'h0004
`define USBSIE_OFF_WINDOW 16'h0008
`define USBSIE_OFF_ADDR 16'h000c
`define USBSIE_OFF_FRML 16'h0010
`define USBSIE_OFF_FRMH 16'h0014
`define USBSIE_OFF_EP_BASE 16'h0020
`define USBSIE_EP_IDX_LSB 2
`define USBSIE_EP_IDX_W 3

// ==========================================================
// usb ram, linear byte address = axi word index
`define USBSIE_DP_FIRST 14'h2000
`define USBSIE_DP_LAST 14'h21ef
`define USBSIE_SP_FIRST 14'h2200
`define USBSIE_SP_LAST 14'h23ff
`define USBSIE_ZERO_LAST 14'h29af
`define USBSIE_DP_BYTES 496
`define USBSIE_SP_BYTES 512

// ==========================================================
// field positions
`define USBSIE_CFG_MOD_EN 0
`define USBSIE_CFG_FULL_SPEED 1
`define USBSIE_CFG_EYE 2
`define USBSIE_EP_STALL 0
`define USBSIE_EP_IN_EN 1
`define USBSIE_EP_OUT_EN 2
`define USBSIE_EP_SETUP_DIS 3
`define USBSIE_EP_HSHK 4
`define USBSIE_WIN_PPBI 1
`define USBSIE_WIN_DIR 2
`define USBSIE_WIN_EP_LSB 3
`define USBSIE_ADDR_RESET 7'h00
`define USBSIE_FIFO_DEPTH 4

// ==========================================================
// bit times on a 4 ns clock
`define USBSIE_CLK_PS 4000
`define USBSIE_FS_BIT_PS 83333
`define USBSIE_LS_BIT_PS 666667
`define USBSIE_FS_BIT_CYC (`USBSIE_FS_BIT_PS / `USBSIE_CLK_PS)
`define USBSIE_LS_BIT_CYC (`USBSIE_LS_BIT_PS / `USBSIE_CLK_PS)

`endif

//--- logic/usbsie_pkg.sv
// types of the usb sie status and endpoint control block
// assumes: compiled before the top module
package usbsie_pkg;
  // ==========================================================
  // token and answer types
  typedef enum logic [1:0] {USBSIE_TOK_OUT, USBSIE_TOK_IN, USBSIE_TOK_SETUP} usbsie_tok_kind_type;
  typedef enum logic [2:0] {
    USBSIE_HS_IGNORE, USBSIE_HS_NONE, USBSIE_HS_ACK, USBSIE_HS_NAK, USBSIE_HS_STALL
  } usbsie_hs_type;

  typedef struct packed {
    logic valid;
    usbsie_tok_kind_type kind;
    logic [6:0] addr;
    logic [3:0] ep;
    logic buf_ready;
    logic bd_stall;
  } usbsie_token_type;

  typedef struct packed {
    logic [3:0] ep;
    logic dir;
    logic ppbi;
  } usbsie_status_type;

  typedef struct packed {
    logic valid;
    usbsie_status_type status;
  } usbsie_done_type;

  typedef struct packed {
    logic valid;
    logic [10:0] frame;
  } usbsie_sof_type;

  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } usbsie_ram_req_type;

  typedef enum logic [1:0] {USBSIE_EYE_IDLE, USBSIE_EYE_SWITCH, USBSIE_EYE_RUN} usbsie_eye_type;
endpackage

//--- testbench/usbsie_assertions.sv
// checker of usbsie_top: handshake, done flag, axi response and eye line timing
// assumes: bound to usbsie_top, one aclk domain
`timescale 1ns/1ps
module usbsie_assertions
  import usbsie_pkg::*;
#(
  parameter int NUM_EP = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire usbsie_pkg::usbsie_token_type token,
  input wire logic hs_valid,
  input wire usbsie_pkg::usbsie_hs_type hs_code,
  input wire usbsie_pkg::usbsie_done_type xfer_done,
  input wire logic transaction_done_flag,
  input wire logic eye_tx_en,
  input wire logic eye_dp,
  input wire logic eye_dm
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // assertions
  a_hs_follows: assert property (token.valid |=> hs_valid)
    else $error("no handshake one cycle after token");
  a_hs_single: assert property (!token.valid |=> !hs_valid)
    else $error("handshake without token");
  a_bad_ep_ignored: assert property (
    token.valid && token.ep >= NUM_EP |=> hs_code == USBSIE_HS_IGNORE)
    else $error("token to missing endpoint answered");
  a_done_cause: assert property (
    $rose(transaction_done_flag) |-> $past(xfer_done.valid, 2) || $past(transaction_done_flag, 2))
    else $error("done flag raised without completion");
  a_read_delay: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not two cycles after address");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_eye_lines: assert property (eye_tx_en |-> eye_dp != eye_dm)
    else $error("eye lines not differential");
  a_eye_first_bit: assert property (
    $rose(eye_tx_en) |-> (!eye_dp && eye_dm) [*4])
    else $error("eye pattern first bit wrong");
endmodule

bind usbsie_top usbsie_assertions #(.NUM_EP(NUM_EP)) i_usbsie_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .token(token),
  .hs_valid(hs_valid), .hs_code(hs_code), .xfer_done(xfer_done),
  .transaction_done_flag(transaction_done_flag), .eye_tx_en(eye_tx_en),
  .eye_dp(eye_dp), .eye_dm(eye_dm)
);

//--- testbench/usbsie_host_model.sv
// usb host model: tokens, sof frames, bus resets and sie completions
// assumes: same aclk as the block; tasks entered just after a rising edge
`timescale 1ns/1ps
module usbsie_host_model
  import usbsie_pkg::*;
(
  input wire logic aclk,
  output usbsie_pkg::usbsie_token_type token,
  output usbsie_pkg::usbsie_done_type xfer_done,
  output usbsie_pkg::usbsie_sof_type sof,
  output logic bus_reset_flag,
  input wire logic hs_valid,
  input wire usbsie_pkg::usbsie_hs_type hs_code
);
  initial begin
    token = '0;
    xfer_done = '0;
    sof = '0;
    bus_reset_flag = 1'b0;
  end
  // ==========================================================
  // released fields carry the inverse of the last value
  task automatic send_token(input usbsie_tok_kind_type k, input logic [6:0] a,
    input logic [3:0] e, input logic br, input logic st, output logic [3:0] ans);
    usbsie_token_type t;
    t = '{1'b1, k, a, e, br, st};
    token <= t;
    @(posedge aclk);
    t = usbsie_token_type'(~t);
    t.valid = 1'b0;
    token <= t;
    #1;
    ans = {hs_valid, hs_code};
  endtask
  task automatic sie_done(input usbsie_status_type s);
    xfer_done <= '{1'b1, s};
    @(posedge aclk);
    xfer_done <= '{1'b0, usbsie_status_type'(~s)};
    @(posedge aclk);
  endtask
  task automatic send_sof(input logic [10:0] f);
    sof <= '{1'b1, f};
    @(posedge aclk);
    sof <= '{1'b0, ~f};
    @(posedge aclk);
  endtask
  task automatic send_bus_reset();
    bus_reset_flag <= 1'b1;
    @(posedge aclk);
    bus_reset_flag <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

//--- testbench/usbsie_top_tb.sv
// self-checking bench of usbsie_top over axi4-lite with a host model
// assumes: usbsie_pkg compiled first
`timescale 1ns/1ps
module usbsie_top_tb;
  import usbsie_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, suspend_request = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  usbsie_token_type token;
  usbsie_done_type xfer_done;
  usbsie_sof_type sof;
  usbsie_ram_req_type sie_ram = '0;
  usbsie_hs_type hs_code;
  logic hs_valid, bus_reset_flag, transaction_done_flag, eye_tx_en, eye_dp, eye_dm;
  logic [7:0] sie_ram_rdata;
  int bad_count = 0;
  int n_compared = 0;
  always #2 aclk = ~aclk;
  usbsie_top #(.NUM_EP(8), .FS_BIT_CYC(4), .LS_BIT_CYC(8)) i_usbsie_top (.*);
  usbsie_host_model i_usbsie_host_model (.aclk(aclk), .token(token), .xfer_done(xfer_done),
    .sof(sof), .bus_reset_flag(bus_reset_flag), .hs_valid(hs_valid), .hs_code(hs_code));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er,
    input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    chk(nm, s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(16'h000c, 32'h0, 2'b00, "address reset");
    wr(16'h000c, 32'h5, 2'b00);
    rd(16'h000c, 32'h5, 2'b00, "address");
    wr(16'h0040, 32'h1, 2'b10);
    rd(16'h0040, 32'h0, 2'b10, "unmapped");
    $display("t_regs done");
  endtask
  task automatic t_tokens();
    logic [15:0] tbl [10] = '{16'h2022, 16'h1003, 16'h0121, 16'h1120, 16'h2220,
      16'h0320, 16'h1322, 16'h1034, 16'h0920, 16'h0020};
    logic [3:0] ans;
    wr(16'h0020, 32'h16, 2'b00);
    wr(16'h0024, 32'h04, 2'b00);
    wr(16'h0028, 32'h1e, 2'b00);
    wr(16'h002c, 32'h12, 2'b00);
    for (int i = 0; i < 10; i++) begin
      i_usbsie_host_model.send_token(usbsie_tok_kind_type'(tbl[i][13:12]), (i == 9) ? 7'h06 :
        7'h05, tbl[i][11:8], tbl[i][5], tbl[i][4], ans);
      chk("handshake", {28'h0, ans}, {28'h0, 1'b1, tbl[i][2:0]});
    end
    rd(16'h0020, 32'h17, 2'b00, "stall set");
    cycles(10);
    rd(16'h0020, 32'h17, 2'b00, "stall kept");
    wr(16'h0020, 32'h16, 2'b00);
    rd(16'h0020, 32'h16, 2'b00, "stall cleared");
    $display("t_tokens done");
  endtask
  task automatic t_fifo();
    logic [5:0] st [4] = '{6'h05, 6'h12, 6'h1f, 6'h2c};
    logic [3:0] ans;
    int n;
    for (int i = 0; i < 4; i++) begin
      i_usbsie_host_model.sie_done(usbsie_status_type'(st[i]));
      if (i == 0) begin
        cycles(0);
        chk("done flag", {31'h0, transaction_done_flag}, 32'h1);
        rd(16'h0008, {25'h0, st[0], 1'b0}, 2'b00, "window first");
      end
    end
    i_usbsie_host_model.send_token(USBSIE_TOK_IN, 7'h05, 4'h0, 1'b1, 1'b0, ans);
    chk("full nak", {28'h0, ans}, {28'h0, 1'b1, USBSIE_HS_NAK});
    for (int i = 0; i < 4; i++) begin
      rd(16'h0008, {25'h0, st[i], 1'b0}, 2'b00, "window");
      wr(16'h0004, 32'h1, 2'b00);
      n = 0;
      while (transaction_done_flag !== 1'b1 && n < 6) begin
        cycles(1);
        n++;
      end
      chk("flag after pop", {31'h0, transaction_done_flag}, {31'h0, i < 3});
    end
    $display("t_fifo done");
  endtask
  task automatic t_frame();
    logic [10:0] f [2] = '{11'h5a3, 11'h7ff};
    for (int i = 0; i < 2; i++) begin
      i_usbsie_host_model.send_sof(f[i]);
      rd(16'h0010, {24'h0, f[i][7:0]}, 2'b00, "frame low");
      rd(16'h0014, {29'h0, f[i][10:8]}, 2'b00, "frame high");
      wr(16'h0014, 32'h0, 2'b00);
      cycles(20);
      rd(16'h0014, {29'h0, f[i][10:8]}, 2'b00, "frame held");
    end
    wr(16'h000c, 32'h2a, 2'b00);
    i_usbsie_host_model.send_bus_reset();
    rd(16'h000c, 32'h0, 2'b00, "bus reset address");
    $display("t_frame done");
  endtask
  task automatic t_ram();
    logic [15:0] ad [4] = '{16'h8000, 16'h87bc, 16'h8800, 16'h8ffc};
    for (int i = 0; i < 4; i++) begin
      wr(ad[i], 32'h5a + i, 2'b00);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], 32'h5a + i, 2'b00, "ram");
    end
    rd(16'h87c0, 32'h0, 2'b00, "ram gap");
    sie_ram <= '{1'b1, 9'd1, 8'h77};
    @(posedge aclk);
    sie_ram <= '{1'b0, 9'd0, 8'h88};
    cycles(1);
    chk("sie read", {24'h0, sie_ram_rdata}, 32'h5a);
    rd(16'h8004, 32'h77, 2'b00, "cpu sees sie");
    $display("t_ram done");
  endtask
  task automatic t_eye();
    int n;
    int bit_cyc;
    wr(16'h0000, 32'h4, 2'b00);
    cycles(30);
    chk("eye off", {31'h0, eye_tx_en}, 32'h0);
    for (int sp = 0; sp < 2; sp++) begin
      bit_cyc = sp ? 4 : 8;
      wr(16'h0000, 32'h5 | (sp << 1), 2'b00);
      n = 0;
      while (eye_tx_en !== 1'b1 && n < 40) begin
        cycles(1);
        n++;
      end
      cycles(bit_cyc / 2);
      chk("eye first", {30'h0, eye_dp, eye_dm}, 32'h1);
      cycles(bit_cyc);
      chk("eye second", {30'h0, eye_dp, eye_dm}, 32'h2);
      wr(16'h0000, 32'h0, 2'b00);
      cycles(4);
      chk("eye stop", {31'h0, eye_tx_en}, 32'h0);
    end
    $display("t_eye done");
  endtask
  // ==========================================================
  // run control
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_tokens();
    t_fifo();
    t_frame();
    t_ram();
    t_eye();
    complete_run();
  end
endmodule
